// >>> logic/sbdst_pkg.sv
/*
  constants for the drop statistics and discard table register slice:
  register numbers, field positions, reset values and the init length.
  assumes a 16-bit register number on the host port and 32-bit data.
*/
package sbdst_pkg;

  // ----------------------------------------------------------------
  // register numbers
  // ----------------------------------------------------------------
  localparam logic [15:0] SBDST_OFS_PORT1_DROP = 16'h1c06;
  localparam logic [15:0] SBDST_OFS_PORT2_DROP = 16'h1c07;
  localparam logic [15:0] SBDST_OFS_INIT_STATUS = 16'h1c08;
  localparam logic [15:0] SBDST_OFS_TABLE_CMD = 16'h1c09;
  localparam logic [15:0] SBDST_OFS_TABLE_WDATA = 16'h1c0a;
  localparam logic [15:0] SBDST_OFS_TABLE_RDATA = 16'h1c0b;
  localparam logic [15:0] SBDST_OFS_IRQ_STATUS = 16'h1c10;
  localparam logic [15:0] SBDST_OFS_IRQ_MASK = 16'h1c11;

  // ----------------------------------------------------------------
  // field layout
  // ----------------------------------------------------------------
  localparam int SBDST_READY_BIT = 0;
  localparam int SBDST_DIR_BIT = 4;
  localparam int SBDST_IDX_LSB = 0;
  localparam int SBDST_IDX_W = 4;
  localparam int SBDST_PROB_W = 10;
  localparam int SBDST_ENTRIES = 16;
  localparam int SBDST_USAGE_W = 8;
  localparam int SBDST_IRQ_W = 4;

  // interrupt status bit positions
  localparam int SBDST_IRQ_SAT1 = 0;
  localparam int SBDST_IRQ_SAT2 = 1;
  localparam int SBDST_IRQ_READY = 2;
  localparam int SBDST_IRQ_ACCESS = 3;

  // ----------------------------------------------------------------
  // reset values
  // ----------------------------------------------------------------
  localparam logic [31:0] SBDST_CNT_RESET = 32'h0000_0000;
  localparam logic [31:0] SBDST_CNT_MAX = 32'hffff_ffff;
  localparam logic SBDST_DIR_RESET = 1'h0;
  localparam logic [3:0] SBDST_IDX_RESET = 4'h0;
  localparam logic [9:0] SBDST_PROB_RESET = 10'h000;
  localparam logic [3:0] SBDST_IRQ_RESET = 4'h0;

  // ----------------------------------------------------------------
  // table initialisation length in clk_sys cycles
  // ----------------------------------------------------------------
  localparam logic [10:0] SBDST_INIT_CYCLES = 11'h400;

  // buffer usage band edges for the index map
  localparam logic [7:0] SBDST_BAND_NARROW_END = 8'h40;
  localparam logic [7:0] SBDST_BAND_MID_END = 8'h80;
  localparam logic [3:0] SBDST_BAND_MID_BASE = 4'h8;
  localparam logic [3:0] SBDST_BAND_WIDE_BASE = 4'hc;

  typedef enum logic [0:0] {
    SBDST_INIT_RUN = 1'b0,
    SBDST_INIT_DONE = 1'b1
  } sbdst_init_t;

endpackage

// >>> logic/sbdst_prob_mem.sv
/*
  16 x 10 probability store with one write port and two read ports.
  read port a has its own enable and a registered output that holds
  between reads; port b loads its output register every cycle.
  contents are not cleared by reset.
*/
`timescale 1ns/1ps
module sbdst_prob_mem
  import sbdst_pkg::*;
(
  input wire logic clk_sys,
  input wire logic reset,
  input wire logic wr_en,
  input wire logic [sbdst_pkg::SBDST_IDX_W-1:0] wr_idx,
  input wire logic [sbdst_pkg::SBDST_PROB_W-1:0] wr_data,
  input wire logic rd_a_en,
  input wire logic [sbdst_pkg::SBDST_IDX_W-1:0] rd_a_idx,
  output logic [sbdst_pkg::SBDST_PROB_W-1:0] rd_a_data,
  input wire logic [sbdst_pkg::SBDST_IDX_W-1:0] rd_b_idx,
  output logic [sbdst_pkg::SBDST_PROB_W-1:0] rd_b_data
);
  import sbdst_pkg::*;

  typedef struct packed {
    logic [SBDST_ENTRIES-1:0][SBDST_PROB_W-1:0] mem;
    logic [SBDST_PROB_W-1:0] out_a;
    logic [SBDST_PROB_W-1:0] out_b;
  } sbdst_mem_state_t;

  sbdst_mem_state_t s_q;
  sbdst_mem_state_t s_d;

  always_comb
  begin
    s_d = s_q;
    if (wr_en)
    begin
      s_d.mem[wr_idx] = wr_data;
    end
    if (rd_a_en)
    begin
      s_d.out_a = s_q.mem[rd_a_idx];
    end
    s_d.out_b = s_q.mem[rd_b_idx];
  end

  // entries keep their contents through reset; only the outputs clear
  always_ff @(posedge clk_sys)
  begin
    s_q.mem <= s_d.mem;
    if (reset)
    begin
      s_q.out_a <= SBDST_PROB_RESET;
      s_q.out_b <= SBDST_PROB_RESET;
    end
    else
    begin
      s_q.out_a <= s_d.out_a;
      s_q.out_b <= s_d.out_b;
    end
  end

  assign rd_a_data = s_q.out_a;
  assign rd_b_data = s_q.out_b;

endmodule // sbdst_prob_mem

// >>> logic/sbdst_regs.sv
/*
  buffer manager register slice: clear-on-read saturating drop counters
  for switch ports 1 and 2, the tables ready flag, the random discard
  table command, write data and read data registers, an interrupt
  status/mask pair and the yellow drop probability lookup.
  assumes drop pulses and the usage level come from logic on clk_sys,
  and a host that issues one-cycle read or write strobes.
*/
// Design decision made here: strobed register access.
// Function
// - count each port 1 packet dropped by the buffer manager
// - keep a separate 32-bit drop counter for port 2
// - reading a drop counter returns its value and clears it
// - counters stop at all ones and never wrap until read
// - both drop counters are zero after reset
// - every switch fabric reset restarts table initialisation
// - ready flag reads 0 after reset, sets itself when init completes
// - each command register write launches one table read or write
// - command bit 4 picks direction: 1 read, 0 write, resets to 0
// - command bits 3:0 select one of 16 entries, reset 0
// - index bands: 8 wide to 63, 16 wide to 127, 32 wide to 255
// - after a read command the entry appears in the read data register
// - each entry is a 10-bit yellow drop probability in 1/1024 units
`timescale 1ns/1ps
module sbdst_regs
  import sbdst_pkg::*;
(
  input wire logic clk_sys,
  input wire logic reset,
  input wire logic [15:0] reg_addr,
  input wire logic [31:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [31:0] reg_rdata,
  input wire logic drop_port1,
  input wire logic drop_port2,
  input wire logic [sbdst_pkg::SBDST_USAGE_W-1:0] ingress_usage,
  output logic [sbdst_pkg::SBDST_PROB_W-1:0] yellow_drop_prob,
  output logic tables_ready_flag,
  output logic irq
);
  import sbdst_pkg::*;

  // ----------------------------------------------------------------
  // state
  // ----------------------------------------------------------------
  typedef struct packed {
    logic [31:0] port1_drop_counter;
    logic [31:0] port2_drop_counter;
    sbdst_init_t init_state;
    logic [10:0] init_count;
    logic tables_ready_flag;
    logic access_direction;
    logic [SBDST_IDX_W-1:0] table_index;
    logic [SBDST_PROB_W-1:0] discard_table_write_data;
    logic [SBDST_IRQ_W-1:0] irq_status;
    logic [SBDST_IRQ_W-1:0] irq_mask;
    logic read_pending;
    logic [31:0] rdata;
    logic irq;
    logic [SBDST_PROB_W-1:0] yellow_prob;
  } sbdst_state_t;

  sbdst_state_t s_q;
  sbdst_state_t s_d;

  logic wr_cmd;
  logic rd_cnt1;
  logic rd_cnt2;
  logic [SBDST_IRQ_W-1:0] irq_events;
  logic [SBDST_PROB_W-1:0] mem_rd_a_data;
  logic [SBDST_PROB_W-1:0] mem_rd_b_data;
  logic [SBDST_IDX_W-1:0] usage_index;
  logic table_wr_en;
  logic table_rd_en;

  // ----------------------------------------------------------------
  // address decode
  // ----------------------------------------------------------------
  assign wr_cmd = reg_wr && (reg_addr == SBDST_OFS_TABLE_CMD);
  assign rd_cnt1 = reg_rd && (reg_addr == SBDST_OFS_PORT1_DROP);
  assign rd_cnt2 = reg_rd && (reg_addr == SBDST_OFS_PORT2_DROP);
  assign table_wr_en = wr_cmd && !reg_wdata[SBDST_DIR_BIT];
  assign table_rd_en = wr_cmd && reg_wdata[SBDST_DIR_BIT];

  // ----------------------------------------------------------------
  // buffer usage to table index
  // ----------------------------------------------------------------
  always_comb
  begin
    if (ingress_usage < SBDST_BAND_NARROW_END)
    begin
      usage_index = {1'b0, ingress_usage[5:3]};
    end
    else if (ingress_usage < SBDST_BAND_MID_END)
    begin
      usage_index = SBDST_BAND_MID_BASE | {2'b00, ingress_usage[5:4]};
    end
    else
    begin
      usage_index = SBDST_BAND_WIDE_BASE | {2'b00, ingress_usage[6:5]};
    end
  end

  // ----------------------------------------------------------------
  // probability table
  // ----------------------------------------------------------------
  // contents survive reset and come up undefined
  sbdst_prob_mem u_prob_mem (
    .clk_sys(clk_sys),
    .reset(reset),
    .wr_en(table_wr_en),
    .wr_idx(reg_wdata[SBDST_IDX_W-1:0]),
    .wr_data(s_q.discard_table_write_data),
    .rd_a_en(table_rd_en),
    .rd_a_idx(reg_wdata[SBDST_IDX_W-1:0]),
    .rd_a_data(mem_rd_a_data),
    .rd_b_idx(usage_index),
    .rd_b_data(mem_rd_b_data)
  );

  // ----------------------------------------------------------------
  // next state
  // ----------------------------------------------------------------
  always_comb
  begin
    s_d = s_q;
    irq_events = '0;

    // drop counters: the read returns the old value, a drop in the same
    // cycle as the clearing read starts the new count at one
    // the saturation event fires once, on the step into all ones
    if (rd_cnt1)
    begin
      s_d.port1_drop_counter = {31'h0000_0000, drop_port1};
    end
    else if (drop_port1 && (s_q.port1_drop_counter != SBDST_CNT_MAX))
    begin
      s_d.port1_drop_counter = s_q.port1_drop_counter + 32'h0000_0001;
      irq_events[SBDST_IRQ_SAT1] = (s_q.port1_drop_counter == SBDST_CNT_MAX - 32'h1);
    end

    if (rd_cnt2)
    begin
      s_d.port2_drop_counter = {31'h0000_0000, drop_port2};
    end
    else if (drop_port2 && (s_q.port2_drop_counter != SBDST_CNT_MAX))
    begin
      s_d.port2_drop_counter = s_q.port2_drop_counter + 32'h0000_0001;
      irq_events[SBDST_IRQ_SAT2] = (s_q.port2_drop_counter == SBDST_CNT_MAX - 32'h1);
    end

    // ----------------------------------------------------------------
    // table initialisation after every fabric reset
    // ----------------------------------------------------------------
    case (s_q.init_state)
      SBDST_INIT_RUN:
      begin
        s_d.init_count = s_q.init_count + 11'h001;
        if (s_q.init_count == SBDST_INIT_CYCLES - 11'h001)
        begin
          s_d.init_state = SBDST_INIT_DONE;
          s_d.tables_ready_flag = 1'b1;
          irq_events[SBDST_IRQ_READY] = 1'b1;
        end
      end
      SBDST_INIT_DONE:
      begin
        s_d.tables_ready_flag = 1'b1;
      end
      default:
      begin
        s_d.init_state = SBDST_INIT_RUN;
      end
    endcase

    // ----------------------------------------------------------------
    // command register: each write launches one access
    // ----------------------------------------------------------------
    // index and direction are taken from the written word, so the access
    // uses the new values in the same cycle as the write
    if (wr_cmd)
    begin
      s_d.access_direction = reg_wdata[SBDST_DIR_BIT];
      s_d.table_index = reg_wdata[SBDST_IDX_LSB +: SBDST_IDX_W];
      irq_events[SBDST_IRQ_ACCESS] = !reg_wdata[SBDST_DIR_BIT];
    end
    // a read access is reported once the capture register holds the entry
    s_d.read_pending = table_rd_en;
    if (s_q.read_pending)
    begin
      irq_events[SBDST_IRQ_ACCESS] = 1'b1;
    end

    if (reg_wr && (reg_addr == SBDST_OFS_TABLE_WDATA))
    begin
      s_d.discard_table_write_data = reg_wdata[SBDST_PROB_W-1:0];
    end

    if (reg_wr && (reg_addr == SBDST_OFS_IRQ_MASK))
    begin
      s_d.irq_mask = reg_wdata[SBDST_IRQ_W-1:0];
    end

    // ----------------------------------------------------------------
    // interrupt status: write one to clear, a new event wins
    // ----------------------------------------------------------------
    if (reg_wr && (reg_addr == SBDST_OFS_IRQ_STATUS))
    begin
      s_d.irq_status = s_q.irq_status & ~reg_wdata[SBDST_IRQ_W-1:0];
    end
    s_d.irq_status = s_d.irq_status | irq_events;
    // irq trails the status register by one cycle
    s_d.irq = |(s_q.irq_status & s_q.irq_mask);

    // ----------------------------------------------------------------
    // register read data, valid the cycle after the strobe
    // ----------------------------------------------------------------
    s_d.rdata = 32'h0000_0000;
    if (reg_rd)
    begin
      case (reg_addr)
        SBDST_OFS_PORT1_DROP:
        begin
          s_d.rdata = s_q.port1_drop_counter;
        end
        SBDST_OFS_PORT2_DROP:
        begin
          s_d.rdata = s_q.port2_drop_counter;
        end
        SBDST_OFS_INIT_STATUS:
        begin
          s_d.rdata[SBDST_READY_BIT] = s_q.tables_ready_flag;
        end
        SBDST_OFS_TABLE_CMD:
        begin
          s_d.rdata[SBDST_DIR_BIT] = s_q.access_direction;
          s_d.rdata[SBDST_IDX_LSB +: SBDST_IDX_W] = s_q.table_index;
        end
        SBDST_OFS_TABLE_WDATA:
        begin
          s_d.rdata[SBDST_PROB_W-1:0] = s_q.discard_table_write_data;
        end
        SBDST_OFS_TABLE_RDATA:
        begin
          s_d.rdata[SBDST_PROB_W-1:0] = mem_rd_a_data;
        end
        SBDST_OFS_IRQ_STATUS:
        begin
          s_d.rdata[SBDST_IRQ_W-1:0] = s_q.irq_status;
        end
        SBDST_OFS_IRQ_MASK:
        begin
          s_d.rdata[SBDST_IRQ_W-1:0] = s_q.irq_mask;
        end
        default:
        begin
          s_d.rdata = 32'h0000_0000;
        end
      endcase
    end

    // lookup result for the discard logic
    // two registers deep: memory port b, then this output register
    s_d.yellow_prob = mem_rd_b_data;
  end

  // ----------------------------------------------------------------
  // registers
  // ----------------------------------------------------------------
  always_ff @(posedge clk_sys)
  begin
    if (reset)
    begin
      s_q.port1_drop_counter <= SBDST_CNT_RESET;
      s_q.port2_drop_counter <= SBDST_CNT_RESET;
      s_q.init_state <= SBDST_INIT_RUN;
      s_q.init_count <= 11'h000;
      s_q.tables_ready_flag <= 1'b0;
      s_q.access_direction <= SBDST_DIR_RESET;
      s_q.table_index <= SBDST_IDX_RESET;
      s_q.discard_table_write_data <= SBDST_PROB_RESET;
      s_q.irq_status <= SBDST_IRQ_RESET;
      s_q.irq_mask <= SBDST_IRQ_RESET;
      s_q.read_pending <= 1'b0;
      s_q.rdata <= 32'h0000_0000;
      s_q.irq <= 1'b0;
      s_q.yellow_prob <= SBDST_PROB_RESET;
    end
    else
    begin
      s_q <= s_d;
    end
  end

  // ----------------------------------------------------------------
  // outputs
  // ----------------------------------------------------------------
  assign reg_rdata = s_q.rdata;
  assign yellow_drop_prob = s_q.yellow_prob;
  assign tables_ready_flag = s_q.tables_ready_flag;
  assign irq = s_q.irq;

endmodule // sbdst_regs

// >>> tb/sbdst_regs_asserts.sv
/*
  checker for the sbdst_regs ports: read data timing, reserved bits,
  clear-on-read and the tables ready flag.
  assumes one clock and a synchronous active-high reset.
*/
`timescale 1ns/1ps
module sbdst_regs_asserts
  import sbdst_pkg::*;
(
  input wire logic clk_sys,
  input wire logic reset,
  input wire logic [15:0] reg_addr,
  input wire logic [31:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  input wire logic [31:0] reg_rdata,
  input wire logic drop_port1,
  input wire logic drop_port2,
  input wire logic [sbdst_pkg::SBDST_USAGE_W-1:0] ingress_usage,
  input wire logic [sbdst_pkg::SBDST_PROB_W-1:0] yellow_drop_prob,
  input wire logic tables_ready_flag,
  input wire logic irq
);
  default clocking cb @(posedge clk_sys);
  endclocking
  default disable iff (reset);
  // cycles since reset release, saturating
  logic [10:0] up_q;
  always_ff @(posedge clk_sys)
  begin
    if (reset)
      up_q <= 11'h000;
    else if (up_q != 11'h7ff)
      up_q <= up_q + 11'h001;
  end
  AST_RDATA_IDLE: assert property (!$past(reg_rd) |-> reg_rdata == 32'h0)
    else $error("read data not zero outside a read answer");
  AST_CLEAR_ON_READ: assert property ((reg_rd && reg_addr == SBDST_OFS_PORT2_DROP
    && !drop_port2) ##1 (reg_rd && reg_addr == SBDST_OFS_PORT2_DROP)
    |=> reg_rdata == 32'h0) else $error("drop counter not cleared by read");
  AST_CMD_RSVD: assert property (reg_rd && reg_addr == SBDST_OFS_TABLE_CMD
    |=> reg_rdata[31:5] == 27'h0) else $error("command reserved bits set");
  AST_STS_RSVD: assert property (reg_rd && reg_addr == SBDST_OFS_INIT_STATUS
    |=> reg_rdata[31:1] == 31'h0) else $error("status reserved bits set");
  AST_STS_READY: assert property (reg_rd && reg_addr == SBDST_OFS_INIT_STATUS
    |=> reg_rdata[0] == $past(tables_ready_flag)) else $error("status bit differs");
  AST_RDATA_RSVD: assert property (reg_rd && reg_addr == SBDST_OFS_TABLE_RDATA
    |=> reg_rdata[31:10] == 22'h0) else $error("table read data upper bits set");
  AST_READY_RESET: assert property ($past(reset) |-> !tables_ready_flag)
    else $error("ready flag high right after reset");
  AST_READY_HOLD: assert property (tables_ready_flag |=> tables_ready_flag)
    else $error("ready flag dropped");
  AST_READY_EARLY: assert property (up_q < SBDST_INIT_CYCLES |-> !tables_ready_flag)
    else $error("ready flag set too early");
  AST_READY_LATE: assert property (up_q >= SBDST_INIT_CYCLES |-> tables_ready_flag)
    else $error("ready flag not set after init");
  cover property (reg_rd && reg_addr == SBDST_OFS_INIT_STATUS && tables_ready_flag);
  cover property (reg_wr && reg_addr == SBDST_OFS_TABLE_CMD && reg_wdata[4]);
  cover property (irq);
endmodule // sbdst_regs_asserts

bind sbdst_regs sbdst_regs_asserts u_sbdst_regs_asserts (.clk_sys(clk_sys), .reset(reset),
  .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
  .reg_rdata(reg_rdata), .drop_port1(drop_port1), .drop_port2(drop_port2),
  .ingress_usage(ingress_usage), .yellow_drop_prob(yellow_drop_prob),
  .tables_ready_flag(tables_ready_flag), .irq(irq));

// >>> tb/tb_top.sv
/*
  self-checking bench for sbdst_regs: register tasks, drop counting,
  init flag, table access, usage lookup and interrupts.
  assumes the checker is bound to the design.
*/
`timescale 1ns/1ps
module tb_top;
  import sbdst_pkg::*;
  logic clk_sys = 1'b0;
  logic reset = 1'b1;
  logic [15:0] reg_addr = 16'h0;
  logic [31:0] reg_wdata = 32'h0;
  logic reg_wr = 1'b0;
  logic reg_rd = 1'b0;
  logic [31:0] reg_rdata;
  logic drop_port1 = 1'b0;
  logic drop_port2 = 1'b0;
  logic [7:0] ingress_usage = 8'h0;
  logic [9:0] yellow_drop_prob;
  logic tables_ready_flag;
  logic irq;
  int err_total = 0;
  int n_tests = 0;
  logic [9:0] tbl [16];
  always #4 clk_sys = ~clk_sys;
  sbdst_regs u_sbdst_regs (.clk_sys(clk_sys), .reset(reset), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
    .drop_port1(drop_port1), .drop_port2(drop_port2), .ingress_usage(ingress_usage),
    .yellow_drop_prob(yellow_drop_prob), .tables_ready_flag(tables_ready_flag), .irq(irq));
  // ----------------------------------------------------------------
  // tasks
  // ----------------------------------------------------------------
  task report_and_stop;
    $display("checks %0d, mismatches %0d", n_tests, err_total);
    if (err_total == 0 && n_tests > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask
  task chk(input string name, input logic [31:0] seen, input logic [31:0] exp);
    n_tests++;
    if (seen !== exp)
    begin
      err_total++;
      $display("[ERR] %s expected %h seen %h", name, exp, seen);
    end
  endtask
  task wr(input logic [15:0] a, input logic [31:0] d);
    reg_addr <= a;
    reg_wdata <= d;
    reg_wr <= 1'b1;
    @(posedge clk_sys);
    reg_wr <= 1'b0;
    @(posedge clk_sys);
  endtask
  task rdc(input string name, input logic [15:0] a, input logic [31:0] exp);
    reg_addr <= a;
    reg_rd <= 1'b1;
    @(posedge clk_sys);
    reg_rd <= 1'b0;
    @(negedge clk_sys);
    chk(name, reg_rdata, exp);
    @(posedge clk_sys);
  endtask
  task do_reset;
    reset <= 1'b1;
    repeat (6) @(posedge clk_sys);
    reset <= 1'b0;
    @(posedge clk_sys);
  endtask
  task wait_ready;
    int i;
    for (i = 0; i < 1200 && tables_ready_flag !== 1'b1; i++)
      @(negedge clk_sys);
    chk("ready flag", {31'h0, tables_ready_flag}, 32'h1);
    if (tables_ready_flag !== 1'b1)
      report_and_stop();
    @(posedge clk_sys);
  endtask
  function automatic int band(input int u);
    if (u < 64)
      return u / 8;
    if (u < 128)
      return 8 + (u - 64) / 16;
    return 12 + (u - 128) / 32;
  endfunction
  // ----------------------------------------------------------------
  // sequence
  // ----------------------------------------------------------------
  initial
  begin
    do_reset();
    rdc("p1 reset", SBDST_OFS_PORT1_DROP, 32'h0);
    rdc("p2 reset", SBDST_OFS_PORT2_DROP, 32'h0);
    rdc("cmd reset", SBDST_OFS_TABLE_CMD, 32'h0);
    rdc("status reset", SBDST_OFS_INIT_STATUS, 32'h0);
    rdc("unmapped", 16'h1c0f, 32'h0);
    $display("test reset values done");
    drop_port1 <= 1'b1;
    drop_port2 <= 1'b1;
    repeat (3) @(posedge clk_sys);
    drop_port2 <= 1'b0;
    repeat (2) @(posedge clk_sys);
    drop_port1 <= 1'b0;
    rdc("p1 count", SBDST_OFS_PORT1_DROP, 32'h5);
    rdc("p1 cleared", SBDST_OFS_PORT1_DROP, 32'h0);
    // two reads back to back
    reg_addr <= SBDST_OFS_PORT2_DROP;
    reg_rd <= 1'b1;
    @(posedge clk_sys);
    @(negedge clk_sys);
    chk("p2 count", reg_rdata, 32'h3);
    @(posedge clk_sys);
    reg_rd <= 1'b0;
    @(negedge clk_sys);
    chk("p2 cleared", reg_rdata, 32'h0);
    @(posedge clk_sys);
    $display("test drop counters done");
    wait_ready();
    wr(SBDST_OFS_INIT_STATUS, 32'hffff_ffff);
    rdc("status ready", SBDST_OFS_INIT_STATUS, 32'h1);
    wr(SBDST_OFS_TABLE_CMD, 32'hffff_ffef);
    rdc("cmd fields", SBDST_OFS_TABLE_CMD, 32'h0f);
    for (int i = 0; i < 16; i++)
    begin
      tbl[i] = 10'(i * 68 + 3);
      wr(SBDST_OFS_TABLE_WDATA, {22'h0, tbl[i]});
      wr(SBDST_OFS_TABLE_CMD, 32'(i));
    end
    rdc("wdata back", SBDST_OFS_TABLE_WDATA, {22'h0, tbl[15]});
    for (int i = 0; i < 16; i++)
    begin
      wr(SBDST_OFS_TABLE_CMD, 32'h10 | 32'(i));
      rdc("table entry", SBDST_OFS_TABLE_RDATA, {22'h0, tbl[i]});
    end
    rdc("cmd read dir", SBDST_OFS_TABLE_CMD, 32'h1f);
    for (int u = 0; u < 256; u++)
    begin
      ingress_usage <= 8'(u);
      repeat (2) @(posedge clk_sys);
      @(negedge clk_sys);
      chk("lookup", {22'h0, yellow_drop_prob}, {22'h0, tbl[band(u)]});
      @(posedge clk_sys);
    end
    $display("test table done");
    chk("irq masked", {31'h0, irq}, 32'h0);
    wr(SBDST_OFS_IRQ_MASK, 32'h8);
    rdc("irq mask", SBDST_OFS_IRQ_MASK, 32'h8);
    rdc("irq status", SBDST_OFS_IRQ_STATUS, 32'hc);
    chk("irq raised", {31'h0, irq}, 32'h1);
    wr(SBDST_OFS_IRQ_STATUS, 32'h8);
    @(posedge clk_sys);
    chk("irq cleared", {31'h0, irq}, 32'h0);
    rdc("irq status left", SBDST_OFS_IRQ_STATUS, 32'h4);
    $display("test interrupt done");
    do_reset();
    chk("ready after reset", {31'h0, tables_ready_flag}, 32'h0);
    rdc("cmd after reset", SBDST_OFS_TABLE_CMD, 32'h0);
    wait_ready();
    $display("test second reset done");
    report_and_stop();
  end
endmodule // tb_top
